// [lorui_map.svh]
// constant map of the logical-or instruction unit: opcodes, addresses, field positions, reset values
`ifndef LORUI_MAP_SVH
`define LORUI_MAP_SVH

// ==========================================================
// opcodes
`define LORUI_OPC_RN_HI   5'h09
`define LORUI_OPC_DIR     8'h45
`define LORUI_OPC_IND0    8'h46
`define LORUI_OPC_IND1    8'h47
`define LORUI_OPC_IMM     8'h44
`define LORUI_OPC_DIRA    8'h42
`define LORUI_OPC_DIRI    8'h43
`define LORUI_OPC_CBIT    8'h72
`define LORUI_OPC_CNBIT   8'hA0

// ==========================================================
// special function addresses
`define LORUI_SFR_ACC     8'hE0
`define LORUI_SFR_PSW     8'hD0
`define LORUI_SFR_PORT    8'h90
`define LORUI_BITRAM_BASE 8'h20

// ==========================================================
// status word fields
`define LORUI_PSW_CY      7
`define LORUI_PSW_RS_HI   4
`define LORUI_PSW_RS_LO   3

// ==========================================================
// reset values
`define LORUI_RST_ACC     8'h00
`define LORUI_RST_PSW     8'h00
`define LORUI_RST_PORT    8'hFF
`define LORUI_RST_BYTE    8'h00

// ==========================================================
// instruction lengths and machine cycles
`define LORUI_LEN1        2'h1
`define LORUI_LEN2        2'h2
`define LORUI_LEN3        2'h3
`define LORUI_CYC1        2'h1
`define LORUI_CYC2        2'h2

`endif

// [lorui_pkg.sv]
// types shared by the logical-or instruction unit
package lorui_pkg;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    LORUI_S_IDLE = 4'h1,
    LORUI_S_PTR  = 4'h2,
    LORUI_S_OPER = 4'h4,
    LORUI_S_WAIT = 4'h8
  } lorui_state_e;

  // ==========================================================
  // decoded instruction forms
  typedef enum logic [3:0] {
    LORUI_OP_NONE  = 4'h0,
    LORUI_OP_RN    = 4'h1,
    LORUI_OP_DIR   = 4'h2,
    LORUI_OP_IND   = 4'h3,
    LORUI_OP_IMM   = 4'h4,
    LORUI_OP_DIRA  = 4'h5,
    LORUI_OP_DIRI  = 4'h6,
    LORUI_OP_CBIT  = 4'h7,
    LORUI_OP_CNBIT = 4'h8
  } lorui_op_e;

  // ==========================================================
  // instruction from fetch
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } lorui_instr_s;

  // retirement report to fetch
  typedef struct packed {
    logic       done;
    logic       unsupported;
    logic [1:0] len;
    logic [1:0] cycles;
  } lorui_retire_s;

endpackage : lorui_pkg

// [lorui_ram.sv]
// internal data memory with registered read port
`timescale 1ns/1ns

module lorui_ram #(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 8
) (
  // clock and freeze
  input  wire logic              clk,
  input  wire logic              ce,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  // read port
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  // ==========================================================
  // no reset: contents are undefined until written, like real scratch ram
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule : lorui_ram

// [lorui_core.sv]
// logical-or instruction unit: decode and execute of the byte and bit or forms
`timescale 1ns/1ns
`include "lorui_map.svh"

module lorui_core
  import lorui_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, freeze
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  // instruction from fetch
  input  wire lorui_instr_s  instrIn,
  output logic               instrReady,
  // retirement report
  output lorui_retire_s      retireOut,
  // architectural state
  output logic [7:0]         accOut,
  output logic [7:0]         pswOut,
  // port pins and output latch
  input  wire logic [7:0]    portPinIn,
  output logic [7:0]         portOut
);

  // ==========================================================
  // decode
  function automatic lorui_op_e decodeOp(input logic [7:0] opc);
    lorui_op_e op;
    op = LORUI_OP_NONE;
    if (opc[7:3] == `LORUI_OPC_RN_HI)
    begin
      op = LORUI_OP_RN;
    end
    else
    begin
      case (opc)
        `LORUI_OPC_DIR:   op = LORUI_OP_DIR;
        `LORUI_OPC_IND0:  op = LORUI_OP_IND;
        `LORUI_OPC_IND1:  op = LORUI_OP_IND;
        `LORUI_OPC_IMM:   op = LORUI_OP_IMM;
        `LORUI_OPC_DIRA:  op = LORUI_OP_DIRA;
        `LORUI_OPC_DIRI:  op = LORUI_OP_DIRI;
        `LORUI_OPC_CBIT:  op = LORUI_OP_CBIT;
        `LORUI_OPC_CNBIT: op = LORUI_OP_CNBIT;
        default:          op = LORUI_OP_NONE;
      endcase
    end
    return op;
  endfunction : decodeOp

  function automatic logic [1:0] lenOf(input lorui_op_e op);
    logic [1:0] n;
    case (op)
      LORUI_OP_DIR, LORUI_OP_IMM, LORUI_OP_DIRA: n = `LORUI_LEN2;
      LORUI_OP_CBIT, LORUI_OP_CNBIT:             n = `LORUI_LEN2;
      LORUI_OP_DIRI:                             n = `LORUI_LEN3;
      default:                                   n = `LORUI_LEN1;
    endcase
    return n;
  endfunction : lenOf

  function automatic logic [1:0] cycOf(input lorui_op_e op);
    logic [1:0] n;
    case (op)
      LORUI_OP_DIRI:  n = `LORUI_CYC2;
      LORUI_OP_CBIT:  n = `LORUI_CYC2;
      LORUI_OP_CNBIT: n = `LORUI_CYC2;
      default:        n = `LORUI_CYC1;
    endcase
    return n;
  endfunction : cycOf

  // ==========================================================
  // state
  lorui_state_e  stateReg;
  lorui_state_e  stateNext;
  lorui_op_e     opReg;
  lorui_op_e     opIn;
  logic [7:0]    arg1Reg;
  logic [7:0]    arg2Reg;
  logic [7:0]    addrReg;
  logic          sfrReg;
  logic [7:0]    accReg;
  logic [7:0]    pswReg;
  logic [7:0]    portLatchReg;
  logic [7:0]    pinS1;
  logic [7:0]    pinS2;
  logic [7:0]    pinS3;
  logic [7:0]    pinReg;
  logic          readyReg;
  lorui_retire_s retireReg;
  logic [7:0]    ramRdata;
  logic [7:0]    ramRaddr;
  logic [7:0]    effAddr;
  logic [1:0]    bank;
  logic          accept;

  assign opIn   = decodeOp(instrIn.opcode);
  assign bank   = pswReg[`LORUI_PSW_RS_HI:`LORUI_PSW_RS_LO];
  assign accept = (stateReg == LORUI_S_IDLE) && instrIn.valid;

  // operand address from the incoming instruction
  always_comb
  begin
    case (opIn)
      LORUI_OP_RN:   effAddr = {3'h0, bank, instrIn.opcode[2:0]};
      LORUI_OP_IND:  effAddr = {3'h0, bank, 2'h0, instrIn.opcode[0]};
      LORUI_OP_CBIT, LORUI_OP_CNBIT:
        effAddr = instrIn.arg1[7] ? {instrIn.arg1[7:3], 3'h0}
                                  : (`LORUI_BITRAM_BASE | {4'h0, instrIn.arg1[6:3]});
      default:       effAddr = instrIn.arg1;
    endcase
  end

  // pointer phase reads the byte that the pointer names
  assign ramRaddr = (stateReg == LORUI_S_PTR) ? ramRdata : effAddr;

  always_comb
  begin
    case (stateReg)
      LORUI_S_IDLE:
        if (!accept || opIn == LORUI_OP_NONE)
          stateNext = LORUI_S_IDLE;
        else if (opIn == LORUI_OP_IND)
          stateNext = LORUI_S_PTR;
        else
          stateNext = LORUI_S_OPER;
      LORUI_S_PTR:  stateNext = LORUI_S_OPER;
      LORUI_S_OPER: stateNext = (cycOf(opReg) == `LORUI_CYC2) ? LORUI_S_WAIT : LORUI_S_IDLE;
      LORUI_S_WAIT: stateNext = LORUI_S_IDLE;
      default:      stateNext = LORUI_S_IDLE;
    endcase
  end

  // ==========================================================
  // execute
  logic [7:0] sfrValue;
  logic [7:0] byteSrc;
  logic [7:0] bitByte;
  logic       bitVal;
  logic       execute;
  logic       destWr;
  logic [7:0] destData;

  always_comb
  begin
    case (addrReg)
      `LORUI_SFR_ACC:  sfrValue = accReg;
      `LORUI_SFR_PSW:  sfrValue = pswReg;
      `LORUI_SFR_PORT: sfrValue = portLatchReg;
      default:         sfrValue = `LORUI_RST_BYTE;
    endcase
  end

  assign execute  = (stateReg == LORUI_S_OPER);
  assign byteSrc  = sfrReg ? sfrValue : ramRdata;
  // bit reads of the port see the pins; byte read-modify-write sees the latch
  assign bitByte  = (sfrReg && addrReg == `LORUI_SFR_PORT) ? pinReg : byteSrc;
  assign bitVal   = bitByte[arg1Reg[2:0]];
  assign destWr   = execute && (opReg == LORUI_OP_DIRA || opReg == LORUI_OP_DIRI);
  assign destData = byteSrc | ((opReg == LORUI_OP_DIRI) ? arg2Reg : accReg);

  lorui_ram #(
    .WIDTH  (8),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (destWr && !sfrReg),
    .waddr (addrReg[ADDR_W-1:0]),
    .wdata (destData),
    .raddr (ramRaddr[ADDR_W-1:0]),
    .rdata (ramRdata)
  );

  // ==========================================================
  // sequencer and latched instruction
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateReg <= LORUI_S_IDLE;
      readyReg <= 1'b1;
      opReg    <= LORUI_OP_NONE;
      arg1Reg  <= `LORUI_RST_BYTE;
      arg2Reg  <= `LORUI_RST_BYTE;
      addrReg  <= `LORUI_RST_BYTE;
      sfrReg   <= 1'b0;
    end
    else if (ce)
    begin
      stateReg <= stateNext;
      readyReg <= (stateNext == LORUI_S_IDLE);
      if (accept)
      begin
        opReg   <= opIn;
        arg1Reg <= instrIn.arg1;
        arg2Reg <= instrIn.arg2;
        addrReg <= effAddr;
        sfrReg  <= effAddr[7] && (opIn != LORUI_OP_IND);
      end
      else if (stateReg == LORUI_S_PTR)
      begin
        addrReg <= ramRdata;
        sfrReg  <= 1'b0;
      end
    end
  end

  // accumulator
  always_ff @(posedge clk)
  begin
    if (rst)
      accReg <= `LORUI_RST_ACC;
    else if (ce && execute)
    begin
      if (opReg == LORUI_OP_RN || opReg == LORUI_OP_DIR || opReg == LORUI_OP_IND)
        accReg <= accReg | byteSrc;
      else if (opReg == LORUI_OP_IMM)
        accReg <= accReg | arg1Reg;
      else if (destWr && sfrReg && addrReg == `LORUI_SFR_ACC)
        accReg <= destData;
    end
  end

  // status word: byte forms touch it only when it is the destination byte
  always_ff @(posedge clk)
  begin
    if (rst)
      pswReg <= `LORUI_RST_PSW;
    else if (ce && execute)
    begin
      if (destWr && sfrReg && addrReg == `LORUI_SFR_PSW)
        pswReg <= destData;
      else if ((opReg == LORUI_OP_CBIT && bitVal) || (opReg == LORUI_OP_CNBIT && !bitVal))
        pswReg[`LORUI_PSW_CY] <= 1'b1;
    end
  end

  // port output latch; bit forms never write, so the source bit keeps its value
  always_ff @(posedge clk)
  begin
    if (rst)
      portLatchReg <= `LORUI_RST_PORT;
    else if (ce && destWr && sfrReg && addrReg == `LORUI_SFR_PORT)
      portLatchReg <= destData;
  end

  // ==========================================================
  // pin synchroniser: value moves on only when stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinS1  <= `LORUI_RST_PORT;
      pinS2  <= `LORUI_RST_PORT;
      pinS3  <= `LORUI_RST_PORT;
      pinReg <= `LORUI_RST_PORT;
    end
    else if (ce)
    begin
      pinS1 <= portPinIn;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      if (pinS2 == pinS3)
        pinReg <= pinS3;
    end
  end

  // ==========================================================
  // retirement report
  always_ff @(posedge clk)
  begin
    if (rst)
      retireReg <= '0;
    else if (ce)
    begin
      retireReg.done        <= (accept && opIn == LORUI_OP_NONE)
                               || ((stateReg == LORUI_S_OPER || stateReg == LORUI_S_WAIT)
                                   && stateNext == LORUI_S_IDLE);
      retireReg.unsupported <= accept && opIn == LORUI_OP_NONE;
      if (accept)
      begin
        retireReg.len    <= lenOf(opIn);
        retireReg.cycles <= cycOf(opIn);
      end
    end
  end

  assign instrReady = readyReg;
  assign retireOut  = retireReg;
  assign accOut     = accReg;
  assign pswOut     = pswReg;
  assign portOut    = portLatchReg;

endmodule : lorui_core

// [lorui_core_monitor.sv]
// assertion checker of the logical-or instruction unit
`timescale 1ns/1ns
module lorui_core_monitor
  import lorui_pkg::*;
(
  // clock and control
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          ce,
  // instruction and retirement
  input wire lorui_instr_s  instrIn,
  input wire logic          instrReady,
  input wire lorui_retire_s retireOut,
  // state
  input wire logic [7:0]    accOut,
  input wire logic [7:0]    pswOut,
  input wire logic [7:0]    portOut
);
  // ========
  // accept decode
  logic       take;
  logic       known;
  logic [7:0] opc;
  assign opc   = instrIn.opcode;
  assign take  = ce && instrReady && instrIn.valid;
  assign known = opc[7:3] == 5'h09 || opc inside {8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h72, 8'hA0};

  default clocking cb @(posedge clk); endclocking
  // a frozen clock enable stretches every window, so checks rest while it is low
  default disable iff (rst || !ce);

  // ========
  // assertions
  // reset itself is the cause here, so it cannot disable the check
  reset_values_a: assert property (disable iff (1'b0) rst && ce |=> accOut == 8'h00 && pswOut == 8'h00
    && portOut == 8'hFF && instrReady && !retireOut.done) else $error("reset values wrong");
  busy_after_take_a: assert property (take && known |=> !instrReady ##[1:2] retireOut.done && instrReady)
    else $error("busy window wrong");
  unsup_retire_a: assert property (take && !known |=> retireOut.done && retireOut.unsupported && instrReady
    && accOut == $past(accOut) && pswOut == $past(pswOut)) else $error("unsupported retire wrong");
  // an unsupported opcode taken on the done cycle retires straight away, a legal second pulse
  done_pulse_a: assert property (retireOut.done && !(take && !known) |=> !retireOut.done)
    else $error("done not a pulse");
  rn_form_a: assert property (take && opc[7:3] == 5'h09 |-> ##2 retireOut.done && retireOut.len == 2'h1
    && retireOut.cycles == 2'h1) else $error("register form length wrong");
  imm_flags_a: assert property (take && opc == 8'h44 |-> ##2 retireOut.done && pswOut == $past(pswOut, 2))
    else $error("immediate form touched flags");
  mask_form_a: assert property (take && opc == 8'h43 |-> ##3 retireOut.done && retireOut.len == 2'h3
    && retireOut.cycles == 2'h2) else $error("mask form length wrong");
  bit_form_a: assert property (take && (opc == 8'h72 || opc == 8'hA0) |-> ##3 retireOut.done
    && retireOut.len == 2'h2 && retireOut.cycles == 2'h2) else $error("bit form length wrong");
  carry_only_a: assert property (take && (opc == 8'h72 || opc == 8'hA0) |-> ##3 pswOut[6:0] == $past(pswOut[6:0], 3)
    && (pswOut[7] || !$past(pswOut[7], 3))) else $error("bit form flag effect wrong");

  // ========
  // covers
  cov_rn_c: cover property (take && opc[7:3] == 5'h09);
  cov_bit_c: cover property (take && opc == 8'hA0);
  cov_unsup_c: cover property (take && !known);
endmodule : lorui_core_monitor

bind lorui_core lorui_core_monitor lorui_core_monitor_inst (.clk, .rst, .ce, .instrIn, .instrReady,
  .retireOut, .accOut, .pswOut, .portOut);

// [testbench.sv]
// self-checking bench of the logical-or instruction unit
`timescale 1ns/1ns
module testbench
  import lorui_pkg::*;
;
  // ========
  // stimulus and observation
  logic          clk       = 1'b0;
  logic          rst       = 1'b1;
  logic          ce        = 1'b1;
  lorui_instr_s  instrIn   = '0;
  logic [7:0]    portPinIn = 8'h00;
  logic          instrReady;
  lorui_retire_s retireOut;
  logic [7:0]    accOut;
  logic [7:0]    pswOut;
  logic [7:0]    portOut;
  int            err_total = 0;
  int            n_tests   = 0;

  always #5 clk = ~clk;

  lorui_core lorui_core_inst (.clk, .rst, .ce, .instrIn, .instrReady, .retireOut, .accOut, .pswOut,
    .portPinIn, .portOut);

  // ========
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // drives the request for one clock without waiting for ready, waits for done with a bound
  task automatic exec(input logic [7:0] opc, a1, a2, input logic [1:0] eLen, eCyc, input logic eUns);
    int n;
    @(posedge clk);
    instrIn <= '{1'b1, opc, a1, a2};
    @(posedge clk);
    instrIn.valid <= 1'b0;
    #1;
    chk({7'h0, instrReady}, {7'h0, eUns}, "ready after take");
    n = 0;
    while (retireOut.done !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({3'h0, retireOut.done, retireOut.unsupported, eUns ? 3'h0 : {retireOut.len, retireOut.cycles[0]}},
      {3'h0, 1'b1, eUns, eUns ? 3'h0 : {eLen, eCyc[0]}}, "retire report");
    if (!eUns)
      chk({6'h0, retireOut.cycles}, {6'h0, eCyc}, "cycles");
  endtask : exec

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // ========
  // scenarios
  task automatic t_byte;
    exec(8'h44, 8'h41, 8'h00, 2'h2, 2'h1, 1'b0);
    chk(accOut, 8'h41, "imm acc");
    chk(pswOut, 8'h00, "imm flags");
    exec(8'h43, 8'hE0, 8'h02, 2'h3, 2'h2, 1'b0);
    chk(accOut, 8'h43, "mask acc");
    exec(8'h43, 8'hD0, 8'h08, 2'h3, 2'h2, 1'b0);
    exec(8'h45, 8'hD0, 8'h00, 2'h2, 2'h1, 1'b0);
    chk(accOut, 8'h4B, "direct acc");
    exec(8'h42, 8'hD0, 8'h00, 2'h2, 2'h1, 1'b0);
    chk(pswOut, 8'h4B, "dest psw");
    chk(accOut, 8'h4B, "dest acc kept");
    $display("test byte forms done");
  endtask : t_byte

  // acc is 4B: bit0 and bit3 one, bit2 zero
  task automatic t_bit;
    exec(8'h72, 8'hE2, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'h4B, "zero keeps carry");
    exec(8'hA0, 8'hE0, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'h4B, "inverted one keeps");
    exec(8'h72, 8'hE3, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'hCB, "one sets carry");
    exec(8'hA0, 8'hE2, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'hCB, "carry held");
    chk(accOut, 8'h4B, "source bit kept");
    $display("test bit forms done");
  endtask : t_bit

  // pins low while latch is high: a pin read would lower the latch
  task automatic t_port;
    exec(8'h43, 8'h90, 8'h00, 2'h3, 2'h2, 1'b0);
    chk(portOut, 8'hFF, "latch kept");
    $display("test port done");
  endtask : t_port

  // bank 1 selected, so register 2 lives at 0x0A
  task automatic t_bank;
    exec(8'h43, 8'h0A, 8'hFF, 2'h3, 2'h2, 1'b0);
    exec(8'h4A, 8'h00, 8'h00, 2'h1, 2'h1, 1'b0);
    chk(accOut, 8'hFF, "bank register");
    exec(8'h46, 8'h00, 8'h00, 2'h1, 2'h1, 1'b0);
    chk(accOut, 8'hFF, "indirect acc");
    exec(8'h00, 8'h00, 8'h00, 2'h0, 2'h0, 1'b1);
    chk(pswOut, 8'hCB, "unsupported flags");
    $display("test bank done");
  endtask : t_bank

  // mid-run reset, a frozen clock enable, then carry set from zero
  task automatic t_restart;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(accOut, 8'h00, "restart acc");
    chk(pswOut, 8'h00, "restart psw");
    chk(portOut, 8'hFF, "restart port");
    @(posedge clk);
    ce      <= 1'b0;
    instrIn <= '{1'b1, 8'h44, 8'h01, 8'h00};
    repeat (3) @(posedge clk);
    instrIn.valid <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk(accOut, 8'h00, "frozen acc");
    chk({7'h0, instrReady}, 8'h01, "frozen ready");
    // pins are low, latch is high; synchroniser needs a few edges to settle
    repeat (4) @(posedge clk);
    exec(8'h72, 8'h90, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'h00, "pin zero keeps carry");
    exec(8'hA0, 8'hE0, 8'h00, 2'h2, 2'h2, 1'b0);
    chk(pswOut, 8'h80, "inverted zero sets");
    chk(accOut, 8'h00, "inverted source kept");
    $display("test restart done");
  endtask : t_restart

  // ========
  // main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(accOut, 8'h00, "reset acc");
    chk(pswOut, 8'h00, "reset psw");
    chk(portOut, 8'hFF, "reset port");
    $display("test reset done");
    t_byte();
    t_bit();
    t_port();
    t_bank();
    t_restart();
    final_report();
  end

  // a full run takes under a hundred cycles
  initial
  begin
    #20000;
    err_total++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    final_report();
  end
endmodule : testbench
